// ### dsp_pkg.sv
// Package of the pointer register block: special-function addresses,
// reset values, widths and core operation codes.
// Assumes an 8-bit direct-address special-function bus inside the core.
package dsp_pkg;

  localparam int DATA_W = 8;
  localparam int PTR_W = 16;

  // Special-function addresses
  localparam logic [7:0] ADDR_STACK_POINTER_REG = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH_BYTE = 8'h83;

  // Reset values
  localparam logic [7:0] RST_STACK_POINTER_REG = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_LOW_BYTE = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER_HIGH_BYTE = 8'h00;

  // Byte positions inside the wide data pointer
  localparam int PTR_LOW_LSB = 0;
  localparam int PTR_HIGH_LSB = 8;

  // Stack step
  localparam logic [7:0] STACK_STEP = 8'h01;

  // Stack operation codes from the core
  typedef enum logic [1:0] {
    DSP_STK_NONE = 2'b00,
    DSP_STK_PUSH = 2'b01,
    DSP_STK_POP = 2'b10,
    DSP_STK_RSVD = 2'b11
  } dsp_stk_op_t;

  // Data pointer operation codes from the core
  typedef enum logic [1:0] {
    DSP_DP_NONE = 2'b00,
    DSP_DP_LOAD = 2'b01,
    DSP_DP_INC = 2'b10,
    DSP_DP_RSVD = 2'b11
  } dsp_dp_op_t;

endpackage

// ### dsp_sfr_byte.sv
// One 8-bit special-function register byte with reset value and
// a core update path that the special-function write path overrides.
// Assumes the caller decodes the address into a select.
`timescale 1ns/10ps
module dsp_sfr_byte #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sfr_sel,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic core_upd,
  input wire logic [7:0] core_val,
  output logic [7:0] value
);

  logic [7:0] next_value;

  always_comb begin
    next_value = value;
    if (sfr_sel && sfr_wr) begin
      next_value = sfr_wdata;
    end else if (core_upd) begin
      next_value = core_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

endmodule

// ### dsp_pointer_regs.sv
// Data pointer and stack pointer registers of the core, reachable as
// special-function registers and updated by instruction execution.
// Assumes the core issues at most one stack and one pointer operation a cycle.
`timescale 1ns/10ps

// Operation
// [RQ1] The low pointer byte forms bits 7 to 0 of the 16-bit data pointer.
// [RQ2] The high pointer byte forms bits 15 to 8, and both bytes are readable and writable.
// [RQ3] The 16-bit data pointer is the address of indirect flash and external data accesses.
// [RQ4] The 8-bit stack pointer holds the data-memory location of the top of the stack.
// [RQ5] A push first increments the stack pointer and then writes the byte at the new location.
// [RQ6] Reset loads the stack pointer with seven so the first push lands at eight.
// [RQ7] Software keeps reserved bits at zero and never writes ones to them.
// [RQ8] Software does not rely on accesses to undefined special-function addresses.
// [RQ9] The stack pointer may address any byte of the 256-byte internal data memory.
// [RQ10] After a push the stack pointer addresses the last written location.
// [RQ11] A pop reads the byte at the stack pointer and then decrements it modulo 256.
module dsp_pointer_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [1:0] stk_op,
  input wire logic [7:0] stk_push_data,
  input wire logic [1:0] dp_op,
  input wire logic [15:0] dp_load_val,
  output logic [15:0] wide_data_pointer,
  output logic [7:0] stack_top_pointer,
  output logic iram_we,
  output logic [7:0] iram_addr,
  output logic [7:0] iram_wdata
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic sel_sp;
  logic sel_dpl;
  logic sel_dph;
  logic is_push;
  logic is_pop;
  logic [7:0] next_sp;
  logic sp_upd;
  logic [15:0] next_dp;
  logic dp_upd;
  logic [7:0] dpl_q;
  logic [7:0] dph_q;
  logic [7:0] sp_q;
  logic [7:0] next_rdata;
  logic next_hit;
  logic next_iram_we;
  logic [7:0] next_iram_addr;
  logic [7:0] next_iram_wdata;

  // ----------------------------------------------------------------
  // Address and operation decode
  // ----------------------------------------------------------------
  assign sel_sp = (sfr_addr == dsp_pkg::ADDR_STACK_POINTER_REG);
  assign sel_dpl = (sfr_addr == dsp_pkg::ADDR_DATA_POINTER_LOW_BYTE);
  assign sel_dph = (sfr_addr == dsp_pkg::ADDR_DATA_POINTER_HIGH_BYTE);
  assign is_push = (dsp_pkg::dsp_stk_op_t'(stk_op) == dsp_pkg::DSP_STK_PUSH);
  assign is_pop = (dsp_pkg::dsp_stk_op_t'(stk_op) == dsp_pkg::DSP_STK_POP);

  // ----------------------------------------------------------------
  // Core update values
  // ----------------------------------------------------------------
  always_comb begin
    next_sp = sp_q;
    sp_upd = 1'b0;
    // [RQ9] full 8-bit range
    // [RQ5] increment before push
    if (is_push) begin
      next_sp = sp_q + dsp_pkg::STACK_STEP;
      sp_upd = 1'b1;
    // [RQ11] decrement after pop
    end else if (is_pop) begin
      next_sp = sp_q - dsp_pkg::STACK_STEP;
      sp_upd = 1'b1;
    end
  end

  always_comb begin
    next_dp = wide_data_pointer;
    dp_upd = 1'b0;
    case (dsp_pkg::dsp_dp_op_t'(dp_op))
      dsp_pkg::DSP_DP_LOAD: begin
        next_dp = dp_load_val;
        dp_upd = 1'b1;
      end
      dsp_pkg::DSP_DP_INC: begin
        next_dp = wide_data_pointer + 16'h0001;
        dp_upd = 1'b1;
      end
      default: begin
        next_dp = wide_data_pointer;
        dp_upd = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register bytes
  // ----------------------------------------------------------------
  // Software write wins over a same-cycle core update of that byte
  // [RQ6] reset to seven
  dsp_sfr_byte #(.RESET_VALUE(dsp_pkg::RST_STACK_POINTER_REG)) u_sp (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sfr_sel(sel_sp),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .core_upd(sp_upd),
    .core_val(next_sp),
    .value(sp_q)
  );

  // [RQ1] low pointer byte
  dsp_sfr_byte #(.RESET_VALUE(dsp_pkg::RST_DATA_POINTER_LOW_BYTE)) u_dpl (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sfr_sel(sel_dpl),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .core_upd(dp_upd),
    .core_val(next_dp[dsp_pkg::PTR_LOW_LSB +: 8]),
    .value(dpl_q)
  );

  // [RQ2] high pointer byte
  dsp_sfr_byte #(.RESET_VALUE(dsp_pkg::RST_DATA_POINTER_HIGH_BYTE)) u_dph (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sfr_sel(sel_dph),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .core_upd(dp_upd),
    .core_val(next_dp[dsp_pkg::PTR_HIGH_LSB +: 8]),
    .value(dph_q)
  );

  // ----------------------------------------------------------------
  // Pointer outputs
  // ----------------------------------------------------------------
  // [RQ3] pointer as indirect address
  assign wide_data_pointer = {dph_q, dpl_q};
  // [RQ4] top of stack location
  assign stack_top_pointer = sp_q;

  // ----------------------------------------------------------------
  // Stack memory write and read-back
  // ----------------------------------------------------------------
  // Pop reads use stack_top_pointer; iram_addr is its registered copy, one cycle behind except on a push
  // Write data holds between pushes
  always_comb begin
    next_iram_we = 1'b0;
    next_iram_addr = sp_q;
    next_iram_wdata = iram_wdata;
    // [RQ10] write at incremented location
    if (is_push) begin
      next_iram_we = 1'b1;
      next_iram_addr = next_sp;
      next_iram_wdata = stk_push_data;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    // [RQ8] unmapped reads return zero
    if (sfr_rd) begin
      case (sfr_addr)
        dsp_pkg::ADDR_STACK_POINTER_REG: begin
          next_rdata = sp_q;
          next_hit = 1'b1;
        end
        dsp_pkg::ADDR_DATA_POINTER_LOW_BYTE: begin
          next_rdata = dpl_q;
          next_hit = 1'b1;
        end
        dsp_pkg::ADDR_DATA_POINTER_HIGH_BYTE: begin
          next_rdata = dph_q;
          next_hit = 1'b1;
        end
        default: begin
          next_rdata = 8'h00;
          next_hit = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      iram_we <= 1'b0;
      iram_addr <= 8'h00;
      iram_wdata <= 8'h00;
    end else begin
      iram_we <= next_iram_we;
      iram_addr <= next_iram_addr;
      iram_wdata <= next_iram_wdata;
    end
  end

endmodule

// ### dsp_iram_model.sv
// Internal data memory model on the far side of the pointer block.
// Assumes one-cycle write strobes on the core clock.
`timescale 1ns/10ps
module dsp_iram_model (
  input wire logic sys_clk,
  input wire logic iram_we,
  input wire logic [7:0] iram_addr,
  input wire logic [7:0] iram_wdata,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [256];
  always @(posedge sys_clk) if (iram_we) mem[iram_addr] <= iram_wdata;
  assign rd_data = mem[rd_addr];
endmodule

// ### dsp_pointer_regs_sva.sv
// Checker of the pointer register block ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module dsp_pointer_regs_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic [1:0] stk_op,
  input wire logic [7:0] stk_push_data,
  input wire logic [1:0] dp_op,
  input wire logic [15:0] dp_load_val,
  input wire logic [15:0] wide_data_pointer,
  input wire logic [7:0] stack_top_pointer,
  input wire logic iram_we,
  input wire logic [7:0] iram_addr,
  input wire logic [7:0] iram_wdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic sp_wr;
  assign sp_wr = sfr_wr && sfr_addr == 8'h81;
  sequence s_push;
    stk_op == 2'b01 && !sp_wr;
  endsequence
  sequence s_stored;
    iram_we && iram_addr == stack_top_pointer;
  endsequence
  property p_rst;
    $rose(nrst) |-> stack_top_pointer == 8'h07 && wide_data_pointer == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_push;
    s_push |=> s_stored ##0 stack_top_pointer == $past(stack_top_pointer) + 8'h01
      && iram_wdata == $past(stk_push_data);
  endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_pop;
    stk_op == 2'b10 && !sp_wr |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("bad pop");
  property p_dpl;
    sfr_wr && sfr_addr == 8'h82 |=> wide_data_pointer[7:0] == $past(sfr_wdata);
  endproperty
  a_dpl: assert property (p_dpl) else $error("bad low byte");
  property p_dph;
    sfr_wr && sfr_addr == 8'h83 |=> wide_data_pointer[15:8] == $past(sfr_wdata);
  endproperty
  a_dph: assert property (p_dph) else $error("bad high byte");
  property p_load;
    dp_op == 2'b01 && !(sfr_wr && sfr_addr[7:1] == 7'h41) |=> wide_data_pointer == $past(dp_load_val);
  endproperty
  a_load: assert property (p_load) else $error("bad load");
  property p_rd;
    sfr_rd && sfr_addr == 8'h81 |=> sfr_hit && sfr_rdata == $past(stack_top_pointer);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_unm;
    sfr_rd && (sfr_addr < 8'h81 || sfr_addr > 8'h83) |=> !sfr_hit && sfr_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("bad unmapped read");
endmodule

bind dsp_pointer_regs dsp_pointer_regs_sva u_dsp_pointer_regs_sva (.*);

// ### dsp_pointer_regs_bench.sv
// Self-checking bench of the pointer register block.
// Assumes the memory model answers pop reads at once.
`timescale 1ns/10ps
module dsp_pointer_regs_bench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] stk_push_data = 8'h00;
  logic [1:0] stk_op = 2'b00;
  logic [1:0] dp_op = 2'b00;
  logic [15:0] dp_load_val = 16'h0000;
  logic [7:0] sfr_rdata, stack_top_pointer, iram_addr, iram_wdata, mem_rdata;
  logic sfr_hit, iram_we;
  logic [15:0] wide_data_pointer;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  dsp_pointer_regs u_dsp_pointer_regs (.sys_clk(sys_clk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .stk_op(stk_op), .stk_push_data(stk_push_data), .dp_op(dp_op),
    .dp_load_val(dp_load_val), .wide_data_pointer(wide_data_pointer),
    .stack_top_pointer(stack_top_pointer), .iram_we(iram_we), .iram_addr(iram_addr),
    .iram_wdata(iram_wdata));
  dsp_iram_model u_dsp_iram_model (.sys_clk(sys_clk), .iram_we(iram_we),
    .iram_addr(iram_addr), .iram_wdata(iram_wdata), .rd_addr(stack_top_pointer),
    .rd_data(mem_rdata));
  initial forever #10 sys_clk = ~sys_clk;
  task cyc();
    @(posedge sys_clk);
    #1;
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc();
    sfr_wr = 1'b0;
    cyc();
  endtask
  task sfr_read(input logic [7:0] a, input logic [8:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc();
    sfr_rd = 1'b0;
    chk(16'({sfr_hit, sfr_rdata}), 16'(e));
    cyc();
  endtask
  task stk(input logic [1:0] op, input logic [7:0] d);
    stk_op = op;
    stk_push_data = d;
    cyc();
    stk_op = 2'b00;
    cyc();
  endtask
  initial begin
    repeat (3) cyc();
    nrst = 1'b1;
    sfr_read(8'h81, 9'h107);
    sfr_read(8'h82, 9'h100);
    sfr_read(8'h83, 9'h100);
    $display("end of reset test");
    stk(2'b01, 8'h5a);
    stk(2'b01, 8'hc3);
    cyc();
    chk(16'(stack_top_pointer), 16'h0009);
    chk(16'(mem_rdata), 16'h00c3);
    stk(2'b10, 8'h00);
    chk(16'(mem_rdata), 16'h005a);
    stk(2'b11, 8'h00);
    chk(16'(stack_top_pointer), 16'h0008);
    $display("end of stack test");
    sfr_write(8'h82, 8'ha5);
    sfr_write(8'h83, 8'h3c);
    chk(wide_data_pointer, 16'h3ca5);
    sfr_read(8'h83, 9'h13c);
    dp_op = 2'b01;
    dp_load_val = 16'hffff;
    cyc();
    dp_op = 2'b10;
    cyc();
    dp_op = 2'b11;
    chk(wide_data_pointer, 16'h0000);
    cyc();
    dp_op = 2'b00;
    chk(wide_data_pointer, 16'h0000);
    $display("end of pointer test");
    sfr_write(8'h81, 8'hff);
    stk(2'b01, 8'h77);
    cyc();
    chk(16'(mem_rdata), 16'h0077);
    stk(2'b10, 8'h00);
    chk(16'(stack_top_pointer), 16'h00ff);
    sfr_read(8'h84, 9'h000);
    sfr_read(8'h80, 9'h000);
    $display("end of wrap test");
    print_verdict();
  end
endmodule
